// ===== tdac_master_model.sv
// two-wire bus master model: drives the serial clock, pulls data low
// assumes a pull-up on the data line and a 50 MHz core clock
`timescale 1ns/1ns
module tdac_master_model (
  // clock
  input wire logic core_clk,
  // bus
  output logic scl,
  output logic sda_pull,
  input wire logic sda_wire
);
  // ==========================================================
  // bus phases, 8 core clocks per bit
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // data moves mid-low so the slave sees the clock fall first
  task automatic bit_cycle(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_pull <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda_wire;
    tick(2);
  endtask : bit_cycle

  // also serves as a repeated start in mid-transfer
  task automatic start_cond;
    scl <= 1'b0;
    tick(2);
    sda_pull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
  endtask : start_cond

  task automatic stop_cond;
    scl <= 1'b0;
    tick(2);
    sda_pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(8);
  endtask : stop_cond

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(tx[i], r);
      rx[i] = r;
    end
    bit_cycle(ack_in, ack_out);
  endtask : xfer
endmodule : tdac_master_model

// ===== tdac_pkg.sv
// types shared by the two-wire converter and output setter
// assumes nothing beyond the constants header
package tdac_pkg;

  // ==========================================================
  // sampled bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } tdac_lines_t;

  // ==========================================================
  // transfer states
  typedef enum logic [2:0] {
    TDAC_IDLE = 3'b000,
    TDAC_RX = 3'b001,
    TDAC_RX_ACK = 3'b010,
    TDAC_TX = 3'b011,
    TDAC_TX_ACK = 3'b100,
    TDAC_WAIT = 3'b101
  } tdac_state_t;

endpackage : tdac_pkg

// ===== tdac_regs.svh
// constants of the two-wire converter and output setter
// assumes a 50 MHz core clock and a master that drives the serial clock
//
// Overview of operation
// - setting byte clears to zero at reset: top converter level, outputs low
// - upper five setting bits form the converter code, inverted sense
// - three low setting bits drive the three digital outputs directly
// - answer only the seven-bit slave address in the upper address-byte bits
// - each transaction is start, three bytes, stop
// - data falling while clock high is a start, opening a new transfer
// - data rising while clock high is a stop, ending the transfer
// - master changes data only while clock low; device samples on rise
// - device drives its bit at the falling edge before the sampling rise
// - receiver pulls data low in the ninth clock to acknowledge
// - bytes are eight bits, most significant first, then acknowledge
// - first byte after start holds address and direction, one means read
// - write: address, memory byte AAh, setting byte, all acknowledged
// - read: address acknowledged, device returns 00h then setting byte
// - after master acknowledges final byte, device releases the data line
// - both lines high with no transfer puts device in low-power idle
`ifndef TDAC_REGS_SVH
`define TDAC_REGS_SVH

// ==========================================================
// bus addressing
`define TDAC_SLAVE_ADDR 7'h2C
`define TDAC_MEM_WR 8'hAA
`define TDAC_MEM_RD 8'h00

// ==========================================================
// setting byte layout
`define TDAC_SETTING_RST 8'h00
`define TDAC_DAC_RST 5'h1F
`define TDAC_DOUT_RST 3'h0
`define TDAC_DAC_MSB 7
`define TDAC_DAC_LSB 3
`define TDAC_OUT0_BIT 0
`define TDAC_OUT1_BIT 1
`define TDAC_OUT2_BIT 2

// ==========================================================
// byte sequencing
`define TDAC_BYTE_ADDR 2'h0
`define TDAC_BYTE_MEM 2'h1
`define TDAC_BYTE_DATA 2'h2
`define TDAC_LAST_BIT 3'h7

`endif

// ===== tdac_sync.sv
// two-flop synchroniser for the serial bus lines
// assumes lines idle high; first stage feeds only the second
`timescale 1ns/1ns
module tdac_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // asynchronous lines
  input tdac_pkg::tdac_lines_t lines_in,
  // synchronised lines
  output tdac_pkg::tdac_lines_t lines_out
);

  // ==========================================================
  // two stages
  tdac_pkg::tdac_lines_t meta_r;
  tdac_pkg::tdac_lines_t stable_r;

  // reset to the idle-high bus so no false start at release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 2'h3;
      stable_r <= 2'h3;
    end else begin
      meta_r <= lines_in;
      stable_r <= meta_r;
    end
  end

  assign lines_out = stable_r;

endmodule : tdac_sync

// ===== tdac_tb.sv
// self-checking bench for the two-wire converter and output setter
// assumes the master model as far side and a pull-up on the data line
`timescale 1ns/1ns
`include "tdac_regs.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n;
  logic scl;
  logic m_pull;
  logic sda_out;
  logic sda_oe;
  logic idle_lowpower;
  logic [4:0] dac_level;
  logic digital_out_0;
  logic digital_out_1;
  logic digital_out_2;
  wire sda_wire = ~m_pull & (sda_oe ? sda_out : 1'b1);
  int err_total = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h00000009;
  logic [7:0] exp_set = 8'h00;
  logic [7:0] rx;
  logic a0;
  logic a1;
  logic a2;
  logic [7:0] corner [6] = '{8'h00, 8'hFF, 8'h07, 8'hF8, 8'h80, 8'h55};
  logic [7:0] bad_mem [3] = '{8'h55, 8'h00, 8'hAB};
  logic [7:0] bad_adr [4] = '{8'h5A, 8'hD8, 8'h2C, 8'h18};

  always #10 core_clk = ~core_clk;

  // ==========================================================
  // device and far side
  tdac_top uut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .dac_level(dac_level),
    .digital_out_0(digital_out_0), .digital_out_1(digital_out_1),
    .digital_out_2(digital_out_2), .idle_lowpower(idle_lowpower));
  tdac_master_model mst (.core_clk(core_clk), .scl(scl), .sda_pull(m_pull),
    .sda_wire(sda_wire));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // inverted sense: code zero is the top level
  function automatic logic [7:0] pins_of(input logic [7:0] s);
    return {~s[7:3], s[2:0]};
  endfunction : pins_of

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic check_pins;
    mst.tick(2);
    check({dac_level, digital_out_2, digital_out_1, digital_out_0}, pins_of(exp_set));
  endtask : check_pins

  // ==========================================================
  // transactions
  task automatic wr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
    logic ok;
    ok = (a == {`TDAC_SLAVE_ADDR, 1'b0});
    mst.start_cond();
    mst.xfer(a, 1'b1, rx, a0);
    check({7'h00, a0}, {7'h00, ~ok});
    check({7'h00, idle_lowpower}, 8'h00);
    if (ok) begin
      mst.xfer(m, 1'b1, rx, a1);
      mst.xfer(d, 1'b1, rx, a2);
      check({6'h00, a1, a2}, 8'h00);
      if (m == `TDAC_MEM_WR) begin
        exp_set = d;
      end
    end
    mst.stop_cond();
    check({6'h00, sda_oe, idle_lowpower}, 8'h01);
    check_pins();
  endtask : wr

  // master nack on the first returned byte ends the read early
  task automatic rd(input logic nack2);
    mst.start_cond();
    mst.xfer({`TDAC_SLAVE_ADDR, 1'b1}, 1'b1, rx, a0);
    check({7'h00, a0}, 8'h00);
    mst.xfer(8'hFF, nack2, rx, a1);
    check(rx, `TDAC_MEM_RD);
    if (!nack2) begin
      mst.xfer(8'hFF, 1'b0, rx, a2);
      check(rx, exp_set);
    end
    mst.stop_cond();
    check({7'h00, sda_oe}, 8'h00);
  endtask : rd

  // ==========================================================
  // main sequence
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    check_pins();
    mst.tick(8);
    check({6'h00, sda_oe, idle_lowpower}, 8'h01);
    foreach (corner[i]) begin
      wr(8'h58, 8'hAA, corner[i]);
      rd(1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      wr(8'h58, 8'hAA, seed[7:0]);
      rd(1'b0);
    end
    foreach (bad_mem[i]) begin
      wr(8'h58, bad_mem[i], ~exp_set);
    end
    foreach (bad_adr[i]) begin
      wr(bad_adr[i], 8'hAA, ~exp_set);
    end
    rd(1'b1);
    rd(1'b0);
    // aborted write, then a full one after the new start
    mst.start_cond();
    mst.xfer(8'h58, 1'b1, rx, a0);
    mst.xfer(8'hAA, 1'b1, rx, a1);
    wr(8'h58, 8'hAA, 8'h3C);
    // a fourth byte finds no acknowledge
    mst.start_cond();
    mst.xfer(8'h58, 1'b1, rx, a0);
    mst.xfer(8'hAA, 1'b1, rx, a0);
    mst.xfer(8'hC3, 1'b1, rx, a0);
    mst.xfer(8'h99, 1'b1, rx, a1);
    check({7'h00, a1}, 8'h01);
    mst.stop_cond();
    exp_set = 8'hC3;
    check_pins();
    // second reset in mid-run clears the setting
    rst_n <= 1'b0;
    exp_set = 8'h00;
    check_pins();
    rst_n <= 1'b1;
    mst.tick(8);
    rd(1'b0);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    summarize();
  end
endmodule : tb_top

// ===== tdac_top.sv
// two-wire slave holding one converter and output setting byte
// assumes an external master clocking the bus far below core_clk
`timescale 1ns/1ns
`include "tdac_regs.svh"
module tdac_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter and digital outputs
  output logic [4:0] dac_level,
  output logic digital_out_0,
  output logic digital_out_1,
  output logic digital_out_2,
  // power state
  output logic idle_lowpower
);

  // ==========================================================
  // reset release
  logic rst_ff1_r;
  logic rst_ff2_r;
  logic rst_n_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff1_r <= 1'b0;
      rst_ff2_r <= 1'b0;
    end else begin
      rst_ff1_r <= 1'b1;
      rst_ff2_r <= rst_ff1_r;
    end
  end

  assign rst_n_s = rst_ff2_r;

  // ==========================================================
  // line sampling and event detection
  tdac_pkg::tdac_lines_t lines_raw;
  tdac_pkg::tdac_lines_t lines_s;
  tdac_pkg::tdac_lines_t lines_prev_r;

  assign lines_raw = '{scl: scl_in, sda: sda_in};

  tdac_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n_s),
    .lines_in(lines_raw),
    .lines_out(lines_s)
  );

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lines_prev_r <= 2'h3;
    end else begin
      lines_prev_r <= lines_s;
    end
  end

  wire scl_rise_w = lines_s.scl & ~lines_prev_r.scl;
  wire scl_fall_w = ~lines_s.scl & lines_prev_r.scl;
  wire scl_high_w = lines_s.scl & lines_prev_r.scl;
  // data edges only count while clock stays high across both samples
  wire start_w = scl_high_w & lines_prev_r.sda & ~lines_s.sda;
  wire stop_w = scl_high_w & ~lines_prev_r.sda & lines_s.sda;

  // ==========================================================
  // address decode, shared with the checks below
  function automatic logic tdac_addr_hit(input logic [7:0] addr_byte);
    tdac_addr_hit = (addr_byte[7:1] == `TDAC_SLAVE_ADDR);
  endfunction : tdac_addr_hit

  // ==========================================================
  // transfer state
  tdac_pkg::tdac_state_t state_r;
  tdac_pkg::tdac_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [1:0] byte_idx_r;
  logic [1:0] byte_idx_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic rx_done_r;
  logic rx_done_nxt;
  logic is_read_r;
  logic is_read_nxt;
  logic mem_ok_r;
  logic mem_ok_nxt;
  logic mack_r;
  logic mack_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [7:0] setting_r;
  logic [7:0] setting_nxt;

  wire addr_hit_w = tdac_addr_hit(shift_r);
  wire mem_match_w = (shift_r == `TDAC_MEM_WR);
  wire [7:0] rx_shift_w = {shift_r[6:0], lines_s.sda};
  wire [7:0] tx_shift_w = {tx_r[6:0], 1'b0};
  wire [7:0] rd_first_w = `TDAC_MEM_RD;

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_idx_nxt = byte_idx_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    rx_done_nxt = rx_done_r;
    is_read_nxt = is_read_r;
    mem_ok_nxt = mem_ok_r;
    mack_nxt = mack_r;
    oe_nxt = oe_r;
    setting_nxt = setting_r;
    if (start_w) begin
      // a repeated start also lands here and aborts the old transfer
      state_nxt = tdac_pkg::TDAC_RX;
      bit_cnt_nxt = 3'h0;
      byte_idx_nxt = `TDAC_BYTE_ADDR;
      rx_done_nxt = 1'b0;
      is_read_nxt = 1'b0;
      mem_ok_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (stop_w) begin
      state_nxt = tdac_pkg::TDAC_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        tdac_pkg::TDAC_IDLE: begin
          state_nxt = tdac_pkg::TDAC_IDLE;
        end
        tdac_pkg::TDAC_RX: begin
          if (scl_rise_w) begin
            shift_nxt = rx_shift_w;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == `TDAC_LAST_BIT) begin
              rx_done_nxt = 1'b1;
            end
          end else if (scl_fall_w && rx_done_r) begin
            rx_done_nxt = 1'b0;
            if (byte_idx_r == `TDAC_BYTE_ADDR) begin
              if (addr_hit_w) begin
                is_read_nxt = shift_r[0];
                oe_nxt = 1'b1;
                state_nxt = tdac_pkg::TDAC_RX_ACK;
              end else begin
                state_nxt = tdac_pkg::TDAC_WAIT;
              end
            end else begin
              oe_nxt = 1'b1;
              state_nxt = tdac_pkg::TDAC_RX_ACK;
              if (byte_idx_r == `TDAC_BYTE_MEM) begin
                mem_ok_nxt = mem_match_w;
              end else if (mem_ok_r) begin
                setting_nxt = shift_r;
              end
            end
          end
        end
        tdac_pkg::TDAC_RX_ACK: begin
          if (scl_fall_w) begin
            byte_idx_nxt = byte_idx_r + 2'h1;
            bit_cnt_nxt = 3'h0;
            if (is_read_r) begin
              tx_nxt = rd_first_w;
              oe_nxt = ~rd_first_w[7];
              state_nxt = tdac_pkg::TDAC_TX;
            end else if (byte_idx_r == `TDAC_BYTE_DATA) begin
              oe_nxt = 1'b0;
              state_nxt = tdac_pkg::TDAC_WAIT;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = tdac_pkg::TDAC_RX;
            end
          end
        end
        tdac_pkg::TDAC_TX: begin
          if (scl_fall_w) begin
            if (bit_cnt_r == `TDAC_LAST_BIT) begin
              oe_nxt = 1'b0;
              state_nxt = tdac_pkg::TDAC_TX_ACK;
            end else begin
              tx_nxt = tx_shift_w;
              bit_cnt_nxt = bit_cnt_r + 3'h1;
              oe_nxt = ~tx_r[6];
            end
          end
        end
        tdac_pkg::TDAC_TX_ACK: begin
          if (scl_rise_w) begin
            mack_nxt = ~lines_s.sda;
          end else if (scl_fall_w) begin
            bit_cnt_nxt = 3'h0;
            if (byte_idx_r == `TDAC_BYTE_MEM && mack_r) begin
              byte_idx_nxt = `TDAC_BYTE_DATA;
              tx_nxt = setting_r;
              oe_nxt = ~setting_r[7];
              state_nxt = tdac_pkg::TDAC_TX;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = tdac_pkg::TDAC_WAIT;
            end
          end
        end
        tdac_pkg::TDAC_WAIT: begin
          // extra bytes beyond the three are ignored until stop or a new start
          state_nxt = tdac_pkg::TDAC_WAIT;
        end
        default: begin
          state_nxt = tdac_pkg::TDAC_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= tdac_pkg::TDAC_IDLE;
      bit_cnt_r <= 3'h0;
      byte_idx_r <= 2'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rx_done_r <= 1'b0;
      is_read_r <= 1'b0;
      mem_ok_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      setting_r <= `TDAC_SETTING_RST;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      rx_done_r <= rx_done_nxt;
      is_read_r <= is_read_nxt;
      mem_ok_r <= mem_ok_nxt;
      mack_r <= mack_nxt;
      oe_r <= oe_nxt;
      setting_r <= setting_nxt;
    end
  end

  // ==========================================================
  // output registers
  logic [4:0] dac_level_r;
  logic [2:0] dout_r;
  logic idle_r;
  logic sda_out_r;

  // converter level rises with voltage, so the stored code is inverted
  wire [4:0] dac_level_w = ~setting_r[`TDAC_DAC_MSB:`TDAC_DAC_LSB];
  wire [2:0] dout_w = {setting_r[`TDAC_OUT2_BIT], setting_r[`TDAC_OUT1_BIT],
                       setting_r[`TDAC_OUT0_BIT]};
  wire idle_w = (state_r == tdac_pkg::TDAC_IDLE) & lines_s.scl & lines_s.sda;

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dac_level_r <= `TDAC_DAC_RST;
      dout_r <= `TDAC_DOUT_RST;
      idle_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else begin
      dac_level_r <= dac_level_w;
      dout_r <= dout_w;
      idle_r <= idle_w;
      sda_out_r <= 1'b0;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = sda_out_r;
  assign sda_oe = oe_r;
  assign dac_level = dac_level_r;
  assign digital_out_0 = dout_r[0];
  assign digital_out_1 = dout_r[1];
  assign digital_out_2 = dout_r[2];
  assign idle_lowpower = idle_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_s);

  property p_dac_inverted;
    ##1 dac_level_r == ~$past(setting_r[7:3]);
  endproperty
  a_dac_inverted: assert property (p_dac_inverted) else $error("converter level wrong");

  property p_outputs_follow;
    $changed(setting_r) |-> ##1 dout_r == setting_r[2:0];
  endproperty
  a_outputs_follow: assert property (p_outputs_follow) else $error("outputs wrong");

  property p_foreign_nack;
    state_r == tdac_pkg::TDAC_RX && rx_done_r && scl_fall_w && !start_w && !stop_w
      && byte_idx_r == 2'h0 && !tdac_addr_hit(shift_r) |=> !oe_r [*2];
  endproperty
  a_foreign_nack: assert property (p_foreign_nack) else $error("acked foreign address");

  property p_addr_ack;
    state_r == tdac_pkg::TDAC_RX && rx_done_r && scl_fall_w && !start_w && !stop_w
      && byte_idx_r == 2'h0 && tdac_addr_hit(shift_r) |=> oe_r && state_r == tdac_pkg::TDAC_RX_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack for own address");

  property p_start_opens;
    start_w |=> state_r == tdac_pkg::TDAC_RX && byte_idx_r == 2'h0 && bit_cnt_r == 3'h0;
  endproperty
  a_start_opens: assert property (p_start_opens) else $error("start not taken");

  property p_stop_ends;
    stop_w && !start_w |=> state_r == tdac_pkg::TDAC_IDLE && !oe_r;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop not taken");

  property p_write_commit;
    state_r == tdac_pkg::TDAC_RX && rx_done_r && scl_fall_w && !start_w && !stop_w
      && byte_idx_r == 2'h2 && mem_ok_r |=> setting_r == $past(shift_r);
  endproperty
  a_write_commit: assert property (p_write_commit) else $error("write lost");

  property p_bad_mem_keeps;
    mem_ok_r == 1'b0 |=> $stable(setting_r);
  endproperty
  a_bad_mem_keeps: assert property (p_bad_mem_keeps) else $error("setting changed");

  property p_drive_on_fall;
    $changed(oe_r) |-> $past(scl_fall_w || start_w || stop_w);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("data moved off fall");

  property p_idle_power;
    state_r == tdac_pkg::TDAC_IDLE && lines_s.scl && lines_s.sda |=> idle_r;
  endproperty
  a_idle_power: assert property (p_idle_power) else $error("idle not flagged");

  property p_final_release;
    state_r == tdac_pkg::TDAC_TX_ACK && byte_idx_r == 2'h2 && scl_fall_w && !start_w
      |=> !oe_r && state_r == tdac_pkg::TDAC_WAIT;
  endproperty
  a_final_release: assert property (p_final_release) else $error("line held");

  property p_tx_ack_free;
    state_r == tdac_pkg::TDAC_TX_ACK |-> !oe_r;
  endproperty
  a_tx_ack_free: assert property (p_tx_ack_free) else $error("driving in master ack");

endmodule : tdac_top
